// file: logic/acl_pkg.sv
package acl_pkg;

  // Characters the line handler reacts to
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_BS = 8'h08;
  localparam logic [7:0] CHAR_SP = 8'h20;
  localparam logic [7:0] CHAR_COMMA = 8'h2C;
  localparam logic [7:0] CHAR_MINUS = 8'h2D;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;
  localparam logic [7:0] CHAR_A = 8'h41;
  localparam logic [7:0] CHAR_Z = 8'h5A;

  // Mode entry and configuration register
  localparam logic [7:0] ENTER_TEXT_CMD = 8'h8B;
  localparam logic [7:0] MODE_CFG_INDEX = 8'h43;
  localparam logic [7:0] MODE_CFG_RESET = 8'h00;
  localparam int BOOT_TEXT_BIT = 0;
  localparam int ECHO_LINE_BIT = 4;
  localparam int ECHO_OFF_BIT = 5;

  // Reply status codes
  localparam logic [7:0] STAT_OK = 8'h64;
  localparam logic [7:0] STAT_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD = 8'h02;
  localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
  localparam logic [7:0] STAT_BAD_VALUE = 8'h04;
  localparam logic [7:0] STAT_LOCKED = 8'h05;
  localparam logic [7:0] STAT_UNAVAIL = 8'h06;

  // Line storage
  localparam int LINE_LEN = 32;
  localparam logic [5:0] LINE_MAX = 6'h20;
  localparam int DEC_DIGITS = 10;

  // Command numbers handed to the executor
  localparam logic [7:0] CMD_ROTATE_RIGHT = 8'h01;
  localparam logic [7:0] CMD_ROTATE_LEFT = 8'h02;
  localparam logic [7:0] CMD_MOTOR_HALT = 8'h03;
  localparam logic [7:0] CMD_USER_FUNC_BASE = 8'h40;

  // Keyword operand codes
  localparam logic [31:0] KW_ABSOLUTE = 32'h0000_0000;
  localparam logic [31:0] KW_RELATIVE = 32'h0000_0001;
  localparam logic [31:0] KW_COORD = 32'h0000_0002;

  typedef enum logic [1:0] {SP_NONE, SP_BIN, SP_RUN, SP_STOP} acl_special_t;

  typedef enum {ST_WAIT_ADDR, ST_SKIP, ST_COLLECT, ST_ECHO_LINE, ST_PARSE, ST_DISPATCH,
                ST_EXEC, ST_REPLY} acl_state_t;

  typedef enum {PH_LEAD, PH_MNEM, PH_ARGS} acl_phase_t;

  typedef enum {RP_HOST, RP_OWN, RP_SP1, RP_STAT, RP_SP2, RP_SIGN, RP_VAL, RP_CR} acl_rphase_t;

  typedef struct packed {
    logic [7:0] num;
    logic [7:0] kind;
    logic [7:0] motor;
    logic [31:0] value;
  } acl_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [31:0] value;
  } acl_result_t;

  typedef struct packed {
    logic ok;
    acl_special_t sp;
    logic [7:0] num;
  } acl_lookup_t;

  // Mnemonic text, last four characters packed right aligned
  function automatic acl_lookup_t acl_lookup(input logic [31:0] mn);
    acl_lookup_t r;
    r = '{ok: 1'b1, sp: SP_NONE, num: 8'h00};
    unique case (mn)
      32'h0052_4F52: r.num = CMD_ROTATE_RIGHT;
      32'h0052_4F4C: r.num = CMD_ROTATE_LEFT;
      32'h004D_5354: r.num = CMD_MOTOR_HALT;
      32'h004D_5650: r.num = 8'h04;
      32'h0053_4150: r.num = 8'h05;
      32'h0047_4150: r.num = 8'h06;
      32'h5354_4150: r.num = 8'h07;
      32'h5253_4150: r.num = 8'h08;
      32'h0053_4750: r.num = 8'h09;
      32'h0047_4750: r.num = 8'h0A;
      32'h5354_4750: r.num = 8'h0B;
      32'h5253_4750: r.num = 8'h0C;
      32'h0052_4653: r.num = 8'h0D;
      32'h0053_494F: r.num = 8'h0E;
      32'h0047_494F: r.num = 8'h0F;
      32'h0053_434F: r.num = 8'h1E;
      32'h0047_434F: r.num = 8'h1F;
      32'h0043_434F: r.num = 8'h20;
      32'h0042_494E: r.sp = SP_BIN;
      32'h0052_554E: r.sp = SP_RUN;
      32'h5354_4F50: r.sp = SP_STOP;
      default:
      begin
        if (mn[31:8] == 24'h0055_46 && mn[7:0] >= 8'h30 && mn[7:0] <= 8'h37)
          r.num = CMD_USER_FUNC_BASE + (mn[7:0] - CHAR_ZERO);
        else
          r.ok = 1'b0;
      end
    endcase
    return r;
  endfunction

endpackage

// file: logic/acl_dec_digits.sv
// Serial binary to decimal, one digit per clock, least significant first
module acl_dec_digits (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] value,
  output logic done_ff,
  output logic [3:0] count_ff,
  output logic [acl_pkg::DEC_DIGITS-1:0][3:0] digits_ff
);
  import acl_pkg::*;

  logic [31:0] rem_ff;
  logic [31:0] quot;
  logic [31:0] low;

  // Divider is wide but only one is needed; ten cycles worst case
  assign quot = rem_ff / 32'd10;
  assign low = rem_ff - quot * 32'd10;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done_ff <= 1'b1;
      count_ff <= 4'h0;
      rem_ff <= 32'h0000_0000;
      digits_ff <= '0;
    end
    else if (start)
    begin
      done_ff <= 1'b0;
      count_ff <= 4'h0;
      rem_ff <= value;
    end
    else if (!done_ff)
    begin
      digits_ff[count_ff] <= low[3:0];
      count_ff <= count_ff + 4'h1;
      rem_ff <= quot;
      done_ff <= (quot == 32'h0000_0000); // Zero still yields one digit
    end
  end

endmodule

// file: logic/acl_text_cmd.sv
module acl_text_cmd (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic tx_ready,
  output logic tx_valid_ff,
  output logic [7:0] tx_char_ff,
  input wire logic bin_cmd_valid,
  input wire logic [7:0] bin_cmd_num,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] nv_mode_cfg,
  input wire logic gp_wr,
  input wire logic [7:0] gp_index,
  input wire logic [31:0] gp_wdata,
  output logic [7:0] mode_cfg_ff,
  output logic text_mode_ff,
  output logic cmd_valid_ff,
  output acl_pkg::acl_cmd_t cmd_ff,
  input wire logic exec_done,
  input wire acl_pkg::acl_result_t exec_result,
  output logic prog_start_ff,
  output logic prog_stop_ff
);
  import acl_pkg::*;

  acl_state_t state_ff;
  acl_phase_t phase_ff;
  acl_rphase_t rphase_ff;
  logic init_done_ff;
  logic bin_pending_ff;
  logic [7:0] buf_ff [LINE_LEN];
  logic [5:0] len_ff;
  logic [5:0] ptr_ff;
  logic [31:0] mn_ff, kw_ff, acc_ff;
  logic neg_ff, any_ff;
  logic [1:0] fidx_ff;
  logic [31:0] field_ff [3];
  logic [7:0] err_ff;
  logic [7:0] rstat_ff;
  logic [31:0] rval_ff;
  logic [3:0] em_ff;
  logic conv_start_ff;
  logic [31:0] conv_in;
  logic conv_done;
  logic [3:0] conv_count;
  logic [DEC_DIGITS-1:0][3:0] conv_digits;
  logic [7:0] own_letter, host_letter, pc, send_char;
  logic echo_imm, echo_line, rx_hit, can_send, send_req, sent, digits_ready, last_digit;
  logic is_digit, is_letter, field_end, parse_end, buf_wr;
  logic [31:0] kw_val, fval;
  logic kw_ok;
  acl_lookup_t lk;

  assign own_letter = CHAR_A + module_addr - 8'h01;
  assign host_letter = CHAR_A + host_addr - 8'h01;
  assign echo_imm = !mode_cfg_ff[ECHO_LINE_BIT] && !mode_cfg_ff[ECHO_OFF_BIT];
  assign echo_line = mode_cfg_ff[ECHO_LINE_BIT] && !mode_cfg_ff[ECHO_OFF_BIT];
  assign rx_hit = rx_valid && text_mode_ff;
  assign can_send = !tx_valid_ff || tx_ready;
  assign sent = send_req && can_send;
  assign digits_ready = conv_done && !conv_start_ff;
  assign last_digit = (em_ff + 4'h1 == conv_count);

  // Parser view of the line; past the end it sees the terminator
  assign pc = (ptr_ff >= len_ff) ? CHAR_CR : buf_ff[ptr_ff[4:0]];
  assign is_digit = pc >= CHAR_ZERO && pc <= CHAR_NINE;
  assign is_letter = pc >= CHAR_A && pc <= CHAR_Z;
  assign parse_end = state_ff == ST_PARSE && pc == CHAR_CR;
  assign field_end = state_ff == ST_PARSE && phase_ff == PH_ARGS && (pc == CHAR_COMMA || pc == CHAR_CR);
  assign lk = acl_lookup(mn_ff);

  // Keyword operands, only the trailing four letters are kept
  always_comb
  begin
    kw_ok = 1'b1;
    kw_val = KW_ABSOLUTE;
    unique case (kw_ff)
      32'h0041_4253: kw_val = KW_ABSOLUTE;
      32'h0052_454C: kw_val = KW_RELATIVE;
      32'h4F4F_5244: kw_val = KW_COORD;
      default: kw_ok = 1'b0;
    endcase
    fval = (kw_ff != 32'h0000_0000) ? kw_val : (neg_ff ? -acc_ff : acc_ff);
  end

  // Character to send this cycle; immediate echo goes out while the line is still coming in
  always_comb
  begin
    send_req = 1'b0;
    send_char = CHAR_CR;
    unique case (state_ff)
      ST_WAIT_ADDR, ST_COLLECT:
      begin
        send_req = rx_hit && echo_imm && (state_ff == ST_COLLECT || rx_char == own_letter);
        send_char = rx_char;
      end
      ST_ECHO_LINE:
      begin
        send_req = 1'b1;
        if (ptr_ff == 6'h00)
          send_char = own_letter;
        else if (ptr_ff <= len_ff)
          send_char = buf_ff[ptr_ff[4:0] - 5'h01];
      end
      ST_REPLY:
      begin
        send_req = !(rphase_ff == RP_STAT || rphase_ff == RP_VAL) || digits_ready;
        unique case (rphase_ff)
          RP_HOST: send_char = host_letter;
          RP_OWN: send_char = own_letter;
          RP_SP1, RP_SP2: send_char = CHAR_SP;
          RP_SIGN: send_char = CHAR_MINUS;
          RP_STAT, RP_VAL: send_char = CHAR_ZERO + {4'h0, conv_digits[conv_count - 4'h1 - em_ff]};
          RP_CR: send_char = CHAR_CR;
        endcase
      end
      ST_SKIP, ST_PARSE, ST_DISPATCH, ST_EXEC: ;
    endcase
  end

  // Transmit register; an immediate echo that meets a busy link is dropped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid_ff <= 1'b0;
      tx_char_ff <= 8'h00;
    end
    else if (sent)
    begin
      tx_valid_ff <= 1'b1;
      tx_char_ff <= send_char;
    end
    else if (tx_ready)
      tx_valid_ff <= 1'b0;
  end

  // Line sequencing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_WAIT_ADDR;
      ptr_ff <= 6'h00;
    end
    else
    begin
      unique case (state_ff)
        ST_WAIT_ADDR:
        begin
          ptr_ff <= 6'h00;
          if (rx_hit && rx_char == own_letter)
            state_ff <= ST_COLLECT;
          else if (rx_hit && rx_char != CHAR_CR)
            state_ff <= ST_SKIP;
        end
        ST_SKIP:
          if (rx_hit && rx_char == CHAR_CR)
            state_ff <= ST_WAIT_ADDR;
        ST_COLLECT:
          if (rx_hit && rx_char == CHAR_CR)
            state_ff <= echo_line ? ST_ECHO_LINE : ST_PARSE;
        ST_ECHO_LINE:
          if (sent)
          begin
            ptr_ff <= (ptr_ff > len_ff) ? 6'h00 : ptr_ff + 6'h01;
            if (ptr_ff > len_ff)
              state_ff <= ST_PARSE;
          end
        ST_PARSE:
        begin
          ptr_ff <= ptr_ff + 6'h01;
          if (parse_end)
            state_ff <= ST_DISPATCH;
        end
        ST_DISPATCH:
          state_ff <= (err_ff == 8'h00 && lk.ok && lk.sp == SP_NONE) ? ST_EXEC : ST_REPLY;
        ST_EXEC:
          if (exec_done)
            state_ff <= ST_REPLY;
        ST_REPLY:
          if (sent && rphase_ff == RP_CR)
            state_ff <= ST_WAIT_ADDR;
      endcase
    end
  end

  // Line storage with backspace editing
  assign buf_wr = state_ff == ST_COLLECT && rx_hit && rx_char != CHAR_CR && rx_char != CHAR_BS
                  && len_ff < LINE_MAX;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      len_ff <= 6'h00;
    else if (state_ff == ST_WAIT_ADDR)
      len_ff <= 6'h00;
    else if (state_ff == ST_COLLECT && rx_hit && rx_char == CHAR_BS && len_ff != 6'h00)
      len_ff <= len_ff - 6'h01;
    else if (buf_wr)
      len_ff <= len_ff + 6'h01;
  end

  genvar gi;
  generate
    for (gi = 0; gi < LINE_LEN; gi++)
    begin : g_line
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          buf_ff[gi] <= 8'h00;
        else if (buf_wr && len_ff == 6'(gi))
          buf_ff[gi] <= rx_char;
      end
    end
  endgenerate

  // Mnemonic and operand scanning, one character per clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_ff <= PH_LEAD;
      mn_ff <= 32'h0000_0000;
      kw_ff <= 32'h0000_0000;
      acc_ff <= 32'h0000_0000;
      neg_ff <= 1'b0;
      any_ff <= 1'b0;
      fidx_ff <= 2'h0;
      err_ff <= 8'h00;
      for (int i = 0; i < 3; i++)
        field_ff[i] <= 32'h0000_0000;
    end
    else if (state_ff == ST_COLLECT)
    begin
      phase_ff <= PH_LEAD;
      mn_ff <= 32'h0000_0000;
      kw_ff <= 32'h0000_0000;
      acc_ff <= 32'h0000_0000;
      neg_ff <= 1'b0;
      any_ff <= 1'b0;
      fidx_ff <= 2'h0;
      err_ff <= 8'h00;
      for (int i = 0; i < 3; i++)
        field_ff[i] <= 32'h0000_0000;
    end
    else if (state_ff == ST_PARSE)
    begin
      unique case (phase_ff)
        PH_LEAD:
          if (pc != CHAR_SP && pc != CHAR_CR)
          begin
            phase_ff <= PH_MNEM;
            mn_ff <= {mn_ff[23:0], pc};
          end
        PH_MNEM:
          if (pc == CHAR_SP)
            phase_ff <= PH_ARGS;
          else if (pc != CHAR_CR)
            mn_ff <= {mn_ff[23:0], pc};
        PH_ARGS:
          if (field_end)
          begin
            if (any_ff || pc == CHAR_COMMA)
            begin
              if (fidx_ff == 2'h3 || (kw_ff != 32'h0000_0000 && !kw_ok))
                err_ff <= STAT_BAD_VALUE;
              else
                field_ff[fidx_ff] <= fval;
              fidx_ff <= (fidx_ff == 2'h3) ? fidx_ff : fidx_ff + 2'h1;
            end
            kw_ff <= 32'h0000_0000;
            acc_ff <= 32'h0000_0000;
            neg_ff <= 1'b0;
            any_ff <= 1'b0;
          end
          else if (is_digit)
          begin
            acc_ff <= {acc_ff[28:0], 3'h0} + {acc_ff[30:0], 1'b0} + {24'h0, pc - CHAR_ZERO};
            any_ff <= 1'b1;
          end
          else if (is_letter)
          begin
            kw_ff <= {kw_ff[23:0], pc};
            any_ff <= 1'b1;
          end
          else if (pc == CHAR_MINUS && !any_ff)
            neg_ff <= 1'b1;
          else if (pc != CHAR_SP)
            err_ff <= STAT_BAD_VALUE;
      endcase
    end
  end

  // Hand-off to the executor and program control strobes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_valid_ff <= 1'b0;
      cmd_ff <= '0;
      prog_start_ff <= 1'b0;
      prog_stop_ff <= 1'b0;
      bin_pending_ff <= 1'b0;
    end
    else
    begin
      cmd_valid_ff <= 1'b0;
      prog_start_ff <= 1'b0;
      prog_stop_ff <= 1'b0;
      if (state_ff == ST_WAIT_ADDR)
        bin_pending_ff <= 1'b0;
      if (state_ff == ST_DISPATCH && err_ff == 8'h00 && lk.ok)
      begin
        bin_pending_ff <= lk.sp == SP_BIN;
        prog_start_ff <= lk.sp == SP_RUN;
        prog_stop_ff <= lk.sp == SP_STOP;
        cmd_valid_ff <= lk.sp == SP_NONE;
        cmd_ff.num <= lk.num;
        if (lk.num == CMD_ROTATE_LEFT || lk.num == CMD_ROTATE_RIGHT || lk.num == CMD_MOTOR_HALT)
        begin
          cmd_ff.kind <= 8'h00;
          cmd_ff.motor <= field_ff[0][7:0];
          cmd_ff.value <= field_ff[1];
        end
        else
        begin
          cmd_ff.kind <= field_ff[0][7:0];
          cmd_ff.motor <= field_ff[1][7:0];
          cmd_ff.value <= field_ff[2];
        end
      end
    end
  end

  // Reply assembly: status then signed value, both as decimal text
  assign conv_in = (rphase_ff == RP_STAT) ? {24'h0, rstat_ff} // Start lands one phase late
                   : (rval_ff[31] ? -rval_ff : rval_ff);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rphase_ff <= RP_HOST;
      rstat_ff <= STAT_OK;
      rval_ff <= 32'h0000_0000;
      em_ff <= 4'h0;
      conv_start_ff <= 1'b0;
    end
    else
    begin
      conv_start_ff <= 1'b0;
      if (state_ff == ST_DISPATCH)
      begin
        rphase_ff <= RP_HOST;
        rval_ff <= 32'h0000_0000;
        rstat_ff <= (err_ff != 8'h00) ? err_ff : (lk.ok ? STAT_OK : STAT_BAD_CMD);
      end
      else if (state_ff == ST_EXEC && exec_done)
      begin
        rstat_ff <= exec_result.status;
        rval_ff <= exec_result.value;
      end
      else if (state_ff == ST_REPLY && sent)
      begin
        em_ff <= 4'h0;
        unique case (rphase_ff)
          RP_HOST: rphase_ff <= RP_OWN;
          RP_OWN: rphase_ff <= RP_SP1;
          RP_SP1:
          begin
            rphase_ff <= RP_STAT;
            conv_start_ff <= 1'b1;
          end
          RP_STAT:
          begin
            em_ff <= em_ff + 4'h1;
            if (last_digit)
              rphase_ff <= RP_SP2;
          end
          RP_SP2:
          begin
            rphase_ff <= rval_ff[31] ? RP_SIGN : RP_VAL;
            conv_start_ff <= 1'b1;
          end
          RP_SIGN: rphase_ff <= RP_VAL;
          RP_VAL:
          begin
            em_ff <= em_ff + 4'h1;
            if (last_digit)
              rphase_ff <= RP_CR;
          end
          RP_CR: rphase_ff <= RP_HOST;
        endcase
      end
    end
  end

  acl_dec_digits u_dec (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(conv_start_ff),
    .value(conv_in),
    .done_ff(conv_done),
    .count_ff(conv_count),
    .digits_ff(conv_digits)
  );

  // Mode and configuration; stored setting loads once after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      init_done_ff <= 1'b0;
      mode_cfg_ff <= MODE_CFG_RESET;
      text_mode_ff <= 1'b0;
    end
    else if (!init_done_ff)
    begin
      init_done_ff <= 1'b1;
      mode_cfg_ff <= nv_mode_cfg;
      text_mode_ff <= nv_mode_cfg[BOOT_TEXT_BIT];
    end
    else
    begin
      if (gp_wr && gp_index == MODE_CFG_INDEX)
        mode_cfg_ff <= gp_wdata[7:0];
      if (!text_mode_ff && bin_cmd_valid && bin_cmd_num == ENTER_TEXT_CMD)
        text_mode_ff <= 1'b1;
      else if (state_ff == ST_REPLY && sent && rphase_ff == RP_CR && bin_pending_ff)
        text_mode_ff <= 1'b0;
    end
  end

endmodule

// file: dv/acl_text_cmd_props.sv
module acl_text_cmd_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_ready,
  input wire logic tx_valid_ff,
  input wire logic [7:0] tx_char_ff,
  input wire logic bin_cmd_valid,
  input wire logic [7:0] bin_cmd_num,
  input wire logic [7:0] nv_mode_cfg,
  input wire logic gp_wr,
  input wire logic [7:0] gp_index,
  input wire logic [31:0] gp_wdata,
  input wire logic [7:0] mode_cfg_ff,
  input wire logic text_mode_ff,
  input wire logic cmd_valid_ff,
  input wire logic exec_done,
  input wire logic prog_start_ff,
  input wire logic prog_stop_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  logic [1:0] init_ff;

  // Marks the boot load edge, so requests are only judged after it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      init_ff <= 2'h0;
    else
      init_ff <= {init_ff[0], 1'b1};
  end

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_boot_load: assert property (
    !init_ff[0] |=> mode_cfg_ff == $past(nv_mode_cfg) && text_mode_ff == $past(nv_mode_cfg[0]))
    else $error("boot config not loaded");
  a_cfg_write: assert property (
    init_ff[0] && gp_wr && gp_index == MODE_CFG_INDEX |=> mode_cfg_ff == $past(gp_wdata[7:0]))
    else $error("config write lost");
  a_cfg_stable: assert property (
    init_ff[0] && !(gp_wr && gp_index == MODE_CFG_INDEX) |=> $stable(mode_cfg_ff))
    else $error("config changed without write");
  a_enter_text: assert property (
    init_ff[0] && bin_cmd_valid && bin_cmd_num == ENTER_TEXT_CMD |=> text_mode_ff)
    else $error("text mode not entered");
  a_text_cause: assert property (
    init_ff[1] && $rose(text_mode_ff) |-> $past(bin_cmd_valid) && $past(bin_cmd_num) == 8'h8B)
    else $error("text mode entered without command");
  // Reply CR of the exit line may still be pending; nothing new may start
  a_quiet_binary: assert property (
    !text_mode_ff && !tx_valid_ff |=> !tx_valid_ff)
    else $error("transmit in binary mode");
  a_tx_hold: assert property (
    tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_char_ff))
    else $error("tx char dropped before accept");
  a_exec_reply: assert property (exec_done && text_mode_ff |-> ##[1:40] tx_valid_ff)
    else $error("no reply after execution");
  a_cmd_pulse: assert property (cmd_valid_ff |=> !cmd_valid_ff)
    else $error("command strobe too long");
  a_prog_pulse: assert property (
    prog_start_ff |-> !prog_stop_ff && !cmd_valid_ff ##1 !prog_start_ff)
    else $error("program start strobe wrong");
endmodule

bind acl_text_cmd acl_text_cmd_props u_props (
  .ref_clk(ref_clk), .rst(rst), .tx_ready(tx_ready), .tx_valid_ff(tx_valid_ff),
  .tx_char_ff(tx_char_ff), .bin_cmd_valid(bin_cmd_valid), .bin_cmd_num(bin_cmd_num),
  .nv_mode_cfg(nv_mode_cfg), .gp_wr(gp_wr), .gp_index(gp_index), .gp_wdata(gp_wdata),
  .mode_cfg_ff(mode_cfg_ff), .text_mode_ff(text_mode_ff), .cmd_valid_ff(cmd_valid_ff),
  .exec_done(exec_done), .prog_start_ff(prog_start_ff), .prog_stop_ff(prog_stop_ff)
);

// file: dv/acl_host_model.sv
module acl_host_model (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic tx_valid_ff,
  input wire logic [7:0] tx_char_ff,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];

  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end

  // Terminal takes characters, sometimes slowly
  always @(posedge ref_clk)
  begin
    if (tx_valid_ff && tx_ready)
      got.push_back(tx_char_ff);
    #1 tx_ready = !stall;
  end

  // One line per call; waits out any echo since the block has no receive buffer
  task automatic send(input string s);
    string t;
    int n;
    t = {s, "\r"};
    foreach (t[i])
    begin
      n = 0;
      while (tx_valid_ff && n < 300)
      begin
        @(posedge ref_clk);
        n++;
      end
      @(posedge ref_clk);
      #1 rx_valid = 1'b1;
      rx_char = t[i];
      @(posedge ref_clk);
      #1 rx_valid = 1'b0;
      rx_char = ~t[i]; // Released line shows no stale char
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// file: dv/acl_text_cmd_tb.sv
module acl_text_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  localparam logic [31:0] halt_mn = 32'h004D5354;
  localparam logic [31:0] move_mn = 32'h004D5650;
  localparam logic [31:0] left_mn = 32'h00524F4C;
  localparam logic [31:0] absolute_kw = 32'h00414253;
  localparam logic [31:0] binary_mn = 32'h0042494E;
  logic [39:0] tab[15] = '{40'h004D565004, 40'h0053415005, 40'h0047415006, 40'h5354415007,
    40'h5253415008, 40'h0053475009, 40'h004747500A, 40'h535447500B, 40'h525347500C,
    40'h005246530D, 40'h0053494F0E, 40'h0047494F0F, 40'h0053434F1E, 40'h0047434F1F,
    40'h0043434F20};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic stall, bin_cmd_valid, gp_wr, exec_done, tx_valid_ff, tx_ready, rx_valid;
  logic cmd_valid_ff, text_mode_ff, prog_start_ff, prog_stop_ff;
  logic [7:0] bin_cmd_num, gp_index, nv_mode_cfg, tx_char_ff, rx_char, mode_cfg_ff;
  logic [31:0] gp_wdata;
  logic [31:0] lfsr = 32'h4ADE8366;
  acl_result_t exec_result;
  acl_cmd_t exp_cmd, cmd_ff;
  int fails = 0, samples_checked = 0, cycles = 0, starts = 0, stops = 0, ret = 0;
  string s;

  always #5 ref_clk = ~ref_clk;

  acl_text_cmd uut (
    .ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_char(rx_char), .tx_ready(tx_ready),
    .tx_valid_ff(tx_valid_ff), .tx_char_ff(tx_char_ff), .bin_cmd_valid(bin_cmd_valid),
    .bin_cmd_num(bin_cmd_num), .module_addr(8'h01), .host_addr(8'h02),
    .nv_mode_cfg(nv_mode_cfg), .gp_wr(gp_wr), .gp_index(gp_index), .gp_wdata(gp_wdata),
    .mode_cfg_ff(mode_cfg_ff), .text_mode_ff(text_mode_ff), .cmd_valid_ff(cmd_valid_ff),
    .cmd_ff(cmd_ff), .exec_done(exec_done), .exec_result(exec_result),
    .prog_start_ff(prog_start_ff), .prog_stop_ff(prog_stop_ff)
  );

  acl_host_model host (
    .ref_clk(ref_clk), .stall(stall), .tx_valid_ff(tx_valid_ff), .tx_char_ff(tx_char_ff),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char)
  );

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic string mn(input logic [31:0] v);
    string r = "";
    for (int i = 3; i >= 0; i--)
      if (v[i*8 +: 8] != 8'h00)
        r = $sformatf("%s%c", r, v[i*8 +: 8]);
    return r;
  endfunction

  task automatic chk(input logic [55:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Random stall for the terminal, plus the hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    lfsr <= step(lfsr);
    #1 stall = lfsr[0];
    if (cycles > 40000)
    begin
      fails++;
      end_of_test();
    end
  end

  // Stand-in executor; program strobes counted on the side
  always @(posedge ref_clk)
  begin
    starts += prog_start_ff;
    stops += prog_stop_ff;
    if (cmd_valid_ff)
    begin
      chk(cmd_ff, exp_cmd);
      repeat (3) @(posedge ref_clk);
      #1 exec_done = 1'b1;
      exec_result = '{STAT_OK, ret};
      @(posedge ref_clk);
      #1 exec_done = 1'b0;
    end
  end

  // Expected text is echo then reply; negative status means total silence
  task automatic run_line(input string line, echo, input int stat);
    string e;
    int n;
    e = (stat < 0) ? "" : {echo, $sformatf("BA %0d %0d\r", stat, ret)};
    host.send(line);
    n = 0;
    while (host.got.size() < e.len() && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (30) @(posedge ref_clk);
    chk(host.got.size(), e.len());
    foreach (e[i])
      if (i < host.got.size())
        chk(host.got[i], e[i]);
    host.got.delete();
  endtask

  task automatic reboot(input logic [7:0] v);
    nv_mode_cfg = v;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(mode_cfg_ff, v);
    chk(text_mode_ff, v[0]);
  endtask

  task automatic enter(input logic [7:0] num);
    @(posedge ref_clk);
    #1 bin_cmd_valid = 1'b1;
    bin_cmd_num = num;
    @(posedge ref_clk);
    #1 bin_cmd_valid = 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, v, e);
    @(posedge ref_clk);
    #1 gp_wr = 1'b1;
    gp_index = idx;
    gp_wdata = {lfsr[31:8], v};
    @(posedge ref_clk);
    #1 gp_wr = 1'b0;
    chk(mode_cfg_ff, e);
  endtask

  // Main sequence
  initial
  begin
    {stall, bin_cmd_valid, gp_wr, exec_done} = 4'h0;
    {bin_cmd_num, gp_index, gp_wdata} = 48'h0;
    exec_result = '0;
    exp_cmd = '0;
    reboot(8'h20);
    run_line({"A", mn(halt_mn), " 1"}, "", -1);
    enter(8'h8A);
    chk(text_mode_ff, 1'b0);
    enter(ENTER_TEXT_CMD);
    chk(text_mode_ff, 1'b1);
    wr(8'h42, 8'h00, 8'h20);
    exp_cmd = '{CMD_MOTOR_HALT, 8'h00, 8'h01, 32'h0};
    ret = int'($signed(lfsr[15:0]));
    run_line({"A  ", mn(halt_mn), " 1"}, "", 100);
    ret = 0;
    run_line("ACALC 0,1", "", 2);
    run_line({"A", mn(move_mn), " XYZ,1,5"}, "", 4);
    run_line({"B", mn(halt_mn), " 1"}, "", -1);
    for (int k = 0; k < 23; k++)
    begin
      exp_cmd = '{(k < 15) ? tab[k][7:0] : 8'h40 + 8'(k - 15), 8'h03, 8'h01, 32'h9};
      ret = int'($signed(lfsr[15:0]));
      s = (k < 15) ? mn(tab[k][39:8]) : $sformatf("UF%0d", k - 15);
      run_line({"A", s, " 3,1,9"}, "", 100);
    end
    wr(MODE_CFG_INDEX, 8'h00, 8'h00);
    exp_cmd = '{8'h04, 8'h00, 8'h01, 32'hFFFFFFF9};
    s = {"A ", mn(move_mn), " ", mn(absolute_kw), ",1,-7"};
    run_line(s, {s, "\r"}, 100);
    exp_cmd = '{CMD_ROTATE_RIGHT, 8'h00, 8'h02, 32'h5};
    run_line("AROX\010R 2,5", "AROX\010R 2,5\r", 100);
    run_line({"B", mn(halt_mn), " 1"}, "", -1);
    wr(MODE_CFG_INDEX, 8'h10, 8'h10);
    exp_cmd = '{CMD_ROTATE_LEFT, 8'h00, 8'h02, 32'd500};
    s = {"A", mn(left_mn), " 2,500"};
    run_line(s, {s, "\r"}, 100);
    wr(MODE_CFG_INDEX, 8'h30, 8'h30);
    ret = 0;
    run_line("ARUN", "", 100);
    chk(starts, 1);
    run_line("ASTOP", "", 100);
    chk(stops, 1);
    run_line({"A", mn(binary_mn)}, "", 100);
    chk(text_mode_ff, 1'b0);
    run_line({"A", mn(halt_mn), " 1"}, "", -1);
    enter(ENTER_TEXT_CMD);
    reboot(8'h20);
    reboot(8'h01);
    exp_cmd = '{CMD_MOTOR_HALT, 8'h00, 8'h01, 32'h0};
    ret = int'($signed(lfsr[15:0]));
    s = {"A", mn(halt_mn), " 1"};
    run_line(s, {s, "\r"}, 100);
    end_of_test();
  end
endmodule
